/* File: verilog/umf_pkg.sv */
// umf_pkg: register map, field layouts, reset values and encodings of the serial mode/framing unit
package umf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// byte addresses of the word-aligned registers
	localparam logic [15:0] OFS_MODE     = 16'hFF50; // serial_operation_mode
	localparam logic [15:0] OFS_BASE_SEL = 16'hFF54; // base_clock_select
	localparam logic [15:0] OFS_DIVISOR  = 16'hFF58; // baud_divisor
	localparam logic [15:0] OFS_CTRL     = 16'hFF5C; // serial_control
	localparam logic [15:0] OFS_RX_ERR   = 16'hFF60; // rx_error_status
	localparam logic [15:0] OFS_TX_STAT  = 16'hFF64; // tx_status
	localparam logic [15:0] OFS_TX_BUF   = 16'hFF68; // tx_buffer, write only
	localparam logic [15:0] OFS_RX_BUF   = 16'hFF6C; // rx_buffer, read only
	localparam logic [15:0] OFS_IN_SW    = 16'hFF70; // input_switch_control
	localparam logic [15:0] OFS_P1_DIR   = 16'hFF74; // port1_direction
	localparam logic [15:0] OFS_P1_LATCH = 16'hFF78; // port 1 output latch

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_MODE     = 8'h01;
	localparam logic [3:0] RST_BASE_SEL = 4'h0;
	localparam logic [7:0] RST_DIVISOR  = 8'hFF;
	localparam logic [7:0] RST_CTRL     = 8'h16;
	localparam logic [7:0] RST_IN_SW    = 8'h00;
	localparam logic [7:0] RST_P1_DIR   = 8'hFF;
	localparam logic [7:0] RST_P1_LATCH = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_ORDER_BIT  = 1;     // bit_order_sel
	localparam int CTRL_INV_BIT    = 0;     // tx_invert_sel
	localparam logic [3:0] CTRL_RO = 4'h5;  // read-only bits 5..2 of serial_control
	localparam int RXE_PARITY_BIT  = 2;     // rx_error_status: parity error
	localparam int RXE_FRAME_BIT   = 1;     // rx_error_status: framing error
	localparam int RXE_OVERRUN_BIT = 0;     // rx_error_status: overrun error
	localparam int TXS_BUF_BIT     = 1;     // tx_status: buffer holds data
	localparam int TXS_SHIFT_BIT   = 0;     // tx_status: frame in progress
	localparam int P1_TX_BIT       = 3;     // tx_pin_direction / tx_pin_latch
	localparam int P1_RX_BIT       = 4;     // rx_pin_direction / rx_pin_latch
	localparam int IN_SW_RX_BIT    = 0;     // selects the lin status input

	////////////////////////////////////////////////////////////////////////////////
	// parity encodings of {parity_select_hi, parity_select_lo}
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD  = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;

	// largest legal base clock select, divide by 2^10
	localparam logic [3:0] BASE_SEL_MAX = 4'hA;
	localparam int PRESCALE_W           = 10;
	// character lengths in bits
	localparam logic [3:0] CHAR_LEN_8   = 4'h8;
	localparam logic [3:0] CHAR_LEN_7   = 4'h7;

	////////////////////////////////////////////////////////////////////////////////
	// serial_operation_mode layout, msb first
	typedef struct packed {
		logic unit_power_on;
		logic transmit_enable_bit;
		logic receive_enable_bit;
		logic parity_select_hi;
		logic parity_select_lo;
		logic character_length_sel; // 1: 8 bits, 0: 7 bits
		logic stop_length_sel;      // 1: two stop bits
		logic rx_error_irq_mode;
	} umf_mode_t;

endpackage : umf_pkg

/* File: verilog/umf_baud_gen.sv */
// umf_baud_gen: base clock prescaler and 8-bit divider giving half-bit ticks
`timescale 1ns/1ps
`default_nettype none
module umf_baud_gen #(
	parameter int PRESCALE_W = umf_pkg::PRESCALE_W
) (
	// clock and serial-unit reset
	input  wire logic       mclk,
	input  wire logic       core_rst,
	// restart aligns tick phase to a frame start
	input  wire logic       restart,
	// settings
	input  wire logic [3:0] base_sel,
	input  wire logic [7:0] divisor,
	// one pulse per divider period, two per bit
	output logic            half_tick
);

	logic [PRESCALE_W-1:0] pre_cnt;  // free prescaler
	logic [7:0]            div_cnt;  // divider count

	// base tick once per 2^base_sel cycles; prohibited selects never tick
	wire [PRESCALE_W-1:0] pre_mask  = PRESCALE_W'((1 << base_sel) - 1);
	wire                  sel_ok    = base_sel <= umf_pkg::BASE_SEL_MAX;
	wire                  base_tick = sel_ok && ((pre_cnt & pre_mask) == pre_mask);
	wire                  div_end   = div_cnt >= (divisor - 8'h01);

	////////////////////////////////////////////////////////////////////////////////
	// divider output period is k base ticks; a bit takes two of them
	always_ff @(posedge mclk or posedge core_rst) begin
		if (core_rst) begin
			pre_cnt   <= '0;
			div_cnt   <= 8'h00;
			half_tick <= 1'b0;
		end else if (restart) begin
			pre_cnt   <= '0;
			div_cnt   <= 8'h00;
			half_tick <= 1'b0;
		end else begin
			pre_cnt   <= pre_cnt + PRESCALE_W'(1);
			half_tick <= base_tick && div_end;
			if (base_tick) begin
				div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
			end
		end
	end

endmodule : umf_baud_gen
`default_nettype wire

/* File: verilog/umf_uart_mode_ctrl.sv */
// umf_uart_mode_ctrl: mode control, frame formatting and pin handover of the serial unit
`timescale 1ns/1ps
`default_nettype none
module umf_uart_mode_ctrl (
	// clock and system reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [15:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// shared transmit pin
	output logic             tx_pin_out,
	output logic             tx_pin_oe,
	// shared receive pin
	input  wire logic        rx_pin_in,
	output logic             rx_pin_out,
	output logic             rx_pin_oe,
	// alternate receive source from the lin side
	input  wire logic        lin_status_in
);

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} umf_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} umf_rx_state_t;

	// reverse the character; for 7 bits the result sits in the low 7 bits
	function automatic logic [7:0] umf_reverse(input logic [7:0] d, input logic eight);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[7-i] = d[i];
		end
		return eight ? r : {1'b0, r[7:1]};
	endfunction : umf_reverse

	////////////////////////////////////////////////////////////////////////////////
	// register state
	umf_pkg::umf_mode_t mode;          // serial_operation_mode
	logic [3:0]         base_sel;      // base_clock_select
	logic [7:0]         divisor;       // baud_divisor
	logic               bit_order_sel; // 0 msb first
	logic               tx_invert_sel; // 1 inverted line
	logic [7:0]         in_sw;         // input_switch_control
	logic [7:0]         p1_dir;        // port1_direction
	logic [7:0]         p1_latch;      // port 1 output latch
	logic               core_rst;      // serial-unit reset, follows power bit

	// transmitter
	umf_tx_state_t tx_state;
	logic [7:0]    tx_buf;       // tx_buffer
	logic          tx_buf_full;
	logic [7:0]    tx_shift;
	logic [3:0]    tx_cnt;
	logic          tx_par;       // running xor of sent data
	logic          tx_line;      // frame level before inversion
	logic          tx_more;      // second stop bit pending
	logic          tx_phase;
	logic          tx_half;

	// receiver
	umf_rx_state_t rx_state;
	logic          rx_in;        // selected, forced-high input
	logic          rx_prev;
	logic [7:0]    rx_coll;      // bits in arrival order
	logic [3:0]    rx_cnt;
	logic          rx_par;
	logic          rx_perr;
	logic          rx_phase;
	logic          rx_half;
	logic [7:0]    rx_buf;       // rx_buffer
	logic          rx_full;
	logic [2:0]    rx_err;       // rx_error_status

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	wire req      = avs_read || avs_write;
	wire take     = req && !avs_waitrequest;  // the edge the master sees the answer
	wire wr       = avs_write && take && avs_byteenable[0];
	wire rd       = avs_read && avs_waitrequest;  // read clears land at the capture edge
	wire [7:0] wd = avs_writedata[7:0];

	wire sel_mode   = avs_address == umf_pkg::OFS_MODE;
	wire sel_base   = avs_address == umf_pkg::OFS_BASE_SEL;
	wire sel_div    = avs_address == umf_pkg::OFS_DIVISOR;
	wire sel_ctrl   = avs_address == umf_pkg::OFS_CTRL;
	wire sel_rxerr  = avs_address == umf_pkg::OFS_RX_ERR;
	wire sel_txstat = avs_address == umf_pkg::OFS_TX_STAT;
	wire sel_txbuf  = avs_address == umf_pkg::OFS_TX_BUF;
	wire sel_rxbuf  = avs_address == umf_pkg::OFS_RX_BUF;
	wire sel_insw   = avs_address == umf_pkg::OFS_IN_SW;
	wire sel_p1dir  = avs_address == umf_pkg::OFS_P1_DIR;
	wire sel_p1lat  = avs_address == umf_pkg::OFS_P1_LATCH;

	// frame format straight from the mode register
	wire [1:0] parity   = {mode.parity_select_hi, mode.parity_select_lo};
	wire [3:0] char_len = mode.character_length_sel ? umf_pkg::CHAR_LEN_8
	                                                : umf_pkg::CHAR_LEN_7;
	wire tx_run  = mode.unit_power_on && mode.transmit_enable_bit;
	wire rx_run  = mode.unit_power_on && mode.receive_enable_bit;
	wire tx_tick = tx_half && tx_phase;
	wire rx_samp = rx_half && !rx_phase;
	wire rx_done = (rx_state == RX_STOP) && rx_samp;

	// break flag and trigger bits read 0; writes to them are ignored
	wire [7:0] ctrl_rd = {2'b00, umf_pkg::CTRL_RO, bit_order_sel, tx_invert_sel};
	wire [7:0] txs_rd  = {6'h00, tx_buf_full, tx_state != TX_IDLE};
	wire [7:0] rd_value =
		sel_mode   ? mode :
		sel_base   ? {4'h0, base_sel} :
		sel_div    ? divisor :
		sel_ctrl   ? ctrl_rd :
		sel_rxerr  ? {5'h00, rx_err} :
		sel_txstat ? txs_rd :
		sel_rxbuf  ? rx_buf :
		sel_insw   ? in_sw :
		sel_p1dir  ? p1_dir :
		sel_p1lat  ? p1_latch : 8'h00;

	// line levels with power gating and the input switch
	wire txd_int = mode.unit_power_on ? (tx_line ^ tx_invert_sel) : 1'b1;
	wire rx_src  = in_sw[umf_pkg::IN_SW_RX_BIT] ? lin_status_in : rx_pin_in;

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, then a one-cycle answer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !(req && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= {24'h00_0000, rd_value};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers on the system reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode          <= umf_pkg::RST_MODE;
			base_sel      <= umf_pkg::RST_BASE_SEL;
			divisor       <= umf_pkg::RST_DIVISOR;
			bit_order_sel <= umf_pkg::RST_CTRL[umf_pkg::CTRL_ORDER_BIT];
			tx_invert_sel <= umf_pkg::RST_CTRL[umf_pkg::CTRL_INV_BIT];
			in_sw         <= umf_pkg::RST_IN_SW;
			p1_dir        <= umf_pkg::RST_P1_DIR;
			p1_latch      <= umf_pkg::RST_P1_LATCH;
		end else if (wr) begin
			if (sel_mode) mode <= wd;
			if (sel_base) base_sel <= wd[3:0];
			if (sel_div) divisor <= wd;
			if (sel_ctrl) begin
				bit_order_sel <= wd[umf_pkg::CTRL_ORDER_BIT];
				tx_invert_sel <= wd[umf_pkg::CTRL_INV_BIT];
			end
			if (sel_insw) in_sw <= wd;
			if (sel_p1dir) p1_dir <= wd;
			if (sel_p1lat) p1_latch <= wd;
		end
	end

	// registered so the derived asynchronous reset never glitches
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			core_rst <= 1'b1;
		end else begin
			core_rst <= !mode.unit_power_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pins: port latch and serial line share the pin; buffer on when direction 0
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_pin_out <= 1'b0;
			tx_pin_oe  <= 1'b0;
			rx_pin_out <= 1'b0;
			rx_pin_oe  <= 1'b0;
		end else begin
			tx_pin_out <= p1_latch[umf_pkg::P1_TX_BIT] && txd_int;
			tx_pin_oe  <= !p1_dir[umf_pkg::P1_TX_BIT];
			rx_pin_out <= p1_latch[umf_pkg::P1_RX_BIT];
			rx_pin_oe  <= !p1_dir[umf_pkg::P1_RX_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// baud generators; each restarts while its engine idles
	umf_baud_gen #(.PRESCALE_W(umf_pkg::PRESCALE_W)) u_tx_baud (
		.mclk      (mclk),
		.core_rst  (core_rst),
		.restart   (tx_state == TX_IDLE),
		.base_sel  (base_sel),
		.divisor   (divisor),
		.half_tick (tx_half)
	);

	umf_baud_gen #(.PRESCALE_W(umf_pkg::PRESCALE_W)) u_rx_baud (
		.mclk      (mclk),
		.core_rst  (core_rst),
		.restart   (rx_state == RX_IDLE),
		.base_sel  (base_sel),
		.divisor   (divisor),
		.half_tick (rx_half)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transmitter: buffer, then start / data / parity / stop
	always_ff @(posedge mclk or posedge core_rst) begin
		if (core_rst) begin
			tx_state    <= TX_IDLE;
			tx_buf      <= 8'h00;
			tx_buf_full <= 1'b0;
			tx_shift    <= 8'h00;
			tx_cnt      <= 4'h0;
			tx_par      <= 1'b0;
			tx_line     <= 1'b1;
			tx_more     <= 1'b0;
			tx_phase    <= 1'b0;
		end else if (!tx_run) begin
			tx_state    <= TX_IDLE;
			tx_buf_full <= 1'b0;
			tx_line     <= 1'b1;
			tx_phase    <= 1'b0;
		end else begin
			// a write while the buffer drains refills it; the set wins
			if (wr && sel_txbuf) begin
				tx_buf <= wd;
			end
			if (tx_half) tx_phase <= !tx_phase;
			case (tx_state)
				TX_IDLE: begin
					tx_buf_full <= (wr && sel_txbuf) || tx_buf_full;
					if (tx_buf_full) begin
						tx_buf_full <= wr && sel_txbuf;
						tx_shift    <= bit_order_sel ? tx_buf
						                             : umf_reverse(tx_buf, mode.character_length_sel);
						tx_line     <= 1'b0;
						tx_phase    <= 1'b0;
						tx_state    <= TX_START;
					end
				end
				TX_START: begin
					tx_buf_full <= (wr && sel_txbuf) || tx_buf_full;
					if (tx_tick) begin
						tx_line  <= tx_shift[0];
						tx_par   <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_cnt   <= 4'h1;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					tx_buf_full <= (wr && sel_txbuf) || tx_buf_full;
					if (tx_tick && (tx_cnt != char_len)) begin
						tx_line  <= tx_shift[0];
						tx_par   <= tx_par ^ tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_cnt   <= tx_cnt + 4'h1;
					end else if (tx_tick && (parity == umf_pkg::PAR_NONE)) begin
						tx_line  <= 1'b1;
						tx_more  <= mode.stop_length_sel;
						tx_state <= TX_STOP;
					end else if (tx_tick) begin
						tx_line  <= (parity == umf_pkg::PAR_EVEN) ? tx_par :
						            (parity == umf_pkg::PAR_ODD)  ? !tx_par : 1'b0;
						tx_state <= TX_PARITY;
					end
				end
				TX_PARITY: begin
					tx_buf_full <= (wr && sel_txbuf) || tx_buf_full;
					if (tx_tick) begin
						tx_line  <= 1'b1;
						tx_more  <= mode.stop_length_sel;
						tx_state <= TX_STOP;
					end
				end
				TX_STOP: begin
					tx_buf_full <= (wr && sel_txbuf) || tx_buf_full;
					if (tx_tick && tx_more) begin
						tx_more <= 1'b0;
					end else if (tx_tick) begin
						tx_state <= TX_IDLE;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receiver: mid-bit sampling, first stop bit checked
	always_ff @(posedge mclk or posedge core_rst) begin
		if (core_rst) begin
			rx_state <= RX_IDLE;
			rx_in    <= 1'b1;
			rx_prev  <= 1'b1;
			rx_coll  <= 8'h00;
			rx_cnt   <= 4'h0;
			rx_par   <= 1'b0;
			rx_perr  <= 1'b0;
			rx_phase <= 1'b0;
			rx_buf   <= 8'h00;
			rx_full  <= 1'b0;
			rx_err   <= 3'h0;
		end else begin
			rx_in   <= mode.unit_power_on ? rx_src : 1'b1;
			rx_prev <= rx_in;
			// read clears, but a completing frame in the same cycle wins
			if (rd && sel_rxbuf) rx_full <= 1'b0;
			if (rd && sel_rxerr) rx_err <= 3'h0;
			if (!rx_run) begin
				rx_state <= RX_IDLE;
				rx_phase <= 1'b0;
			end else begin
				if (rx_half) rx_phase <= !rx_phase;
				case (rx_state)
					RX_IDLE: begin
						if (rx_prev && !rx_in) begin
							rx_phase <= 1'b0;
							rx_state <= RX_START;
						end
					end
					RX_START: begin
						if (rx_samp) begin
							rx_coll  <= 8'h00;
							rx_cnt   <= 4'h0;
							rx_par   <= 1'b0;
							rx_perr  <= 1'b0;
							rx_state <= rx_in ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (rx_samp) begin
							rx_coll[rx_cnt[2:0]] <= rx_in;
							rx_par <= rx_par ^ rx_in;
							rx_cnt <= rx_cnt + 4'h1;
							if (rx_cnt == (char_len - 4'h1)) begin
								rx_state <= (parity == umf_pkg::PAR_NONE) ? RX_STOP : RX_PARITY;
							end
						end
					end
					RX_PARITY: begin
						if (rx_samp) begin
							rx_perr  <= (parity == umf_pkg::PAR_EVEN) ? (rx_par ^ rx_in) :
							            (parity == umf_pkg::PAR_ODD)  ? !(rx_par ^ rx_in) : 1'b0;
							rx_state <= RX_STOP;
						end
					end
					RX_STOP: begin
						if (rx_done) begin
							rx_state <= RX_IDLE;
							rx_full  <= 1'b1;
							rx_err[umf_pkg::RXE_PARITY_BIT]  <= rx_perr
								|| (rx_err[umf_pkg::RXE_PARITY_BIT] && !(rd && sel_rxerr));
							rx_err[umf_pkg::RXE_FRAME_BIT]   <= !rx_in
								|| (rx_err[umf_pkg::RXE_FRAME_BIT] && !(rd && sel_rxerr));
							rx_err[umf_pkg::RXE_OVERRUN_BIT] <= rx_full
								|| (rx_err[umf_pkg::RXE_OVERRUN_BIT] && !(rd && sel_rxerr));
							// on overrun the unread byte is kept
							if (!rx_full) begin
								rx_buf <= bit_order_sel ? rx_coll
								                        : umf_reverse(rx_coll, mode.character_length_sel);
							end
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

endmodule : umf_uart_mode_ctrl
`default_nettype wire

/* File: tb/umf_uart_mode_ctrl_chk.sv */
// port-level assertion checker for the serial mode and framing unit
`timescale 1ns/1ps
`default_nettype none
module umf_uart_mode_ctrl_chk (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// register bus
	input wire logic [15:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// pins
	input wire logic        tx_pin_out,
	input wire logic        tx_pin_oe,
	input wire logic        rx_pin_out,
	input wire logic        rx_pin_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// accepted accesses
	wire logic       wtk = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire logic       rtk = avs_read && !avs_waitrequest;
	wire logic       hit = wtk && (avs_address == umf_pkg::OFS_MODE ||
		avs_address == umf_pkg::OFS_P1_LATCH);
	logic      [7:0] sh_mode;  // shadow of the mode register
	logic      [7:0] sh_latch; // shadow of the port latch
	logic      [2:0] quiet;    // cycles since mode or latch last written, held at 7
	// shadows let pin checks know the settings without looking inside
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sh_mode  <= umf_pkg::RST_MODE;
			sh_latch <= umf_pkg::RST_P1_LATCH;
			quiet    <= 3'h0;
		end else begin
			if (wtk && avs_address == umf_pkg::OFS_MODE) sh_mode <= avs_writedata[7:0];
			if (wtk && avs_address == umf_pkg::OFS_P1_LATCH) sh_latch <= avs_writedata[7:0];
			quiet <= hit ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// bus steps
	sequence s_wr(logic [15:0] adr); wtk && avs_address == adr; endsequence
	sequence s_rd(logic [15:0] adr); rtk && avs_address == adr; endsequence
	property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("no answer one cycle after request");
	property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_one: assert property (p_one) else $error("answer longer than one cycle");
	property p_mode; s_rd(umf_pkg::OFS_MODE) |-> avs_readdata == {24'h0, sh_mode}; endproperty
	a_mode: assert property (p_mode) else $error("mode register readback wrong");
	property p_ctrl; s_rd(umf_pkg::OFS_CTRL) |-> avs_readdata[7:2] == 6'h05; endproperty
	a_ctrl: assert property (p_ctrl) else $error("control fixed bits wrong");
	property p_unmap; rtk && (avs_address[1:0] != 2'h0 || avs_address < umf_pkg::OFS_MODE ||
		avs_address > umf_pkg::OFS_P1_LATCH) |-> avs_readdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_stop; !sh_mode[7] && quiet > 3'h3 |-> tx_pin_out == sh_latch[3]; endproperty
	a_stop: assert property (p_stop) else $error("stopped unit disturbs transmit pin");
	property p_clr; rtk && !sh_mode[7] && quiet > 3'h3 && (avs_address == umf_pkg::OFS_RX_ERR
		|| avs_address == umf_pkg::OFS_TX_STAT || avs_address == umf_pkg::OFS_RX_BUF)
		|-> avs_readdata == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("status not cleared while unpowered");
	property p_dir; s_wr(umf_pkg::OFS_P1_DIR) |-> ##2 tx_pin_oe == !$past(avs_writedata[3], 2)
		&& rx_pin_oe == !$past(avs_writedata[4], 2); endproperty
	a_dir: assert property (p_dir) else $error("pin enable does not follow direction");
	property p_latch; s_wr(umf_pkg::OFS_P1_LATCH) |-> ##2
		rx_pin_out == $past(avs_writedata[4], 2); endproperty
	a_latch: assert property (p_latch) else $error("receive pin latch not driven");
endmodule : umf_uart_mode_ctrl_chk
bind umf_uart_mode_ctrl umf_uart_mode_ctrl_chk umf_uart_mode_ctrl_chk_inst (.mclk, .rst,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .tx_pin_out, .tx_pin_oe, .rx_pin_out, .rx_pin_oe);
`default_nettype wire

/* File: tb/umf_remote.sv */
// remote serial transceiver model on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module umf_remote #(
	parameter int BIT = 16 // mclk cycles per bit
) (
	// clock and serial lines
	input  wire logic mclk,
	input  wire logic line_in,
	output logic      line_out
);
	initial line_out = 1'b1; // idle high
	// send n bits, bit 0 first, then back to idle
	task automatic send(input logic [11:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			line_out <= v[i];
			repeat (BIT) @(posedge mclk);
		end
		line_out <= 1'b1;
	endtask : send
	// wait boundedly for a start bit, then sample each bit at its middle
	task automatic grab(input logic inv, input int n, output logic [11:0] v, output logic ok);
		v = 12'hFFF;
		ok = 1'b0;
		for (int t = 0; t < 400 && !ok; t++) begin
			@(posedge mclk);
			ok = ((line_in ^ inv) == 1'b0);
		end
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			v[i] = line_in ^ inv;
			repeat (BIT) @(posedge mclk);
		end
	endtask : grab
endmodule : umf_remote
`default_nettype wire

/* File: tb/umf_uart_mode_ctrl_tb.sv */
// self-checking bench for the serial mode and framing unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module umf_uart_mode_ctrl_tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] avs_address = 16'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, tx_pin_out, tx_pin_oe, rx_pin_out, rx_pin_oe;
	wire logic   rem_out;
	wire logic   tx_line = tx_pin_oe ? tx_pin_out : 1'b1; // pulled up when released
	wire logic   rx_line = rx_pin_oe ? rx_pin_out : rem_out;
	int          n_errors = 0;
	int          n_compared = 0;
	// reset table, last place is unmapped
	localparam logic [15:0] RA [7] = '{umf_pkg::OFS_MODE, umf_pkg::OFS_BASE_SEL,
		umf_pkg::OFS_DIVISOR, umf_pkg::OFS_CTRL, umf_pkg::OFS_IN_SW, umf_pkg::OFS_P1_DIR, 16'hFF7C};
	localparam logic [7:0]  RV [7] = '{8'h01, 8'h00, 8'hFF, 8'h16, 8'h00, 8'hFF, 8'h00};
	// {parity, length, stop, irq mode, lsb first, invert, data}
	localparam logic [14:0] CS [6] = '{{5'b11100, 2'b10, 8'h55}, {5'b11100, 2'b00, 8'h55},
		{5'b11100, 2'b01, 8'h55}, {5'b10010, 2'b10, 8'h36}, {5'b01100, 2'b10, 8'hA7},
		{5'b00000, 2'b00, 8'h5A}};
	umf_uart_mode_ctrl umf_uart_mode_ctrl_inst (.mclk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_pin_out, .tx_pin_oe,
		.rx_pin_in(rx_line), .rx_pin_out, .rx_pin_oe, .lin_status_in(rem_out));
	umf_remote #(.BIT(2 * 8)) umf_remote_inst (.mclk, .line_in(tx_line), .line_out(rem_out));
	always #20 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	// one bus access, held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int t;
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_write     <= w;
		avs_read      <= !w;
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (avs_waitrequest !== 1'b0 && t < 50);
		q = avs_readdata;
		if (t >= 50) begin
			n_errors++;
			conclude();
		end
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge mclk);
	endtask : acc
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		logic [31:0] q;
		acc(1'b0, a, 8'h00, q);
		`CHK(q, {24'h0, e})
	endtask : rd
	// expected line bits of one frame, first bit in bit 0, idle ones above
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [4:0] f,
		input logic lsb, output int n);
		int nb;
		logic p;
		frame = 12'hFFE;
		nb = f[2] ? 8 : 7;
		for (int i = 0; i < nb; i++) frame[i + 1] = lsb ? d[i] : d[nb - 1 - i];
		p = ^(d & (f[2] ? 8'hFF : 8'h7F));
		n = nb + 2 + int'(f[1]) + int'(f[4:3] != umf_pkg::PAR_NONE);
		if (f[4:3] != umf_pkg::PAR_NONE) frame[nb + 1] = (f[4:3] == umf_pkg::PAR_ZERO) ? 1'b0 :
			(f[4:3] == umf_pkg::PAR_EVEN) ? p : !p;
	endfunction : frame
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [11:0] v, got;
		logic [14:0] cs;
		logic ok;
		int n;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) rd(RA[i], RV[i]);
		`CHK(tx_pin_oe, 1'b0)
		$display("test reset values done");
		wr(umf_pkg::OFS_DIVISOR, 8'h08);
		wr(umf_pkg::OFS_P1_DIR, 8'hF7);
		wr(umf_pkg::OFS_P1_LATCH, 8'h08);
		rd(umf_pkg::OFS_P1_DIR, 8'hF7);
		`CHK({tx_pin_oe, rx_pin_oe, tx_pin_out}, 3'b101)
		for (int i = 0; i < 6; i++) begin
			cs = CS[i];
			wr(umf_pkg::OFS_MODE, {3'b000, cs[14:10]});
			wr(umf_pkg::OFS_CTRL, {6'h0, cs[9:8]});
			wr(umf_pkg::OFS_MODE, {3'b100, cs[14:10]});
			wr(umf_pkg::OFS_MODE, {3'b111, cs[14:10]});
			v = frame(cs[7:0], cs[14:10], cs[9], n);
			wr(umf_pkg::OFS_TX_BUF, cs[7:0]);
			fork
				umf_remote_inst.grab(cs[8], n, got, ok);
				umf_remote_inst.send(v, n);
			join
			`CHK({ok, got}, {1'b1, v})
			rd(umf_pkg::OFS_RX_BUF, cs[7:0] & (cs[12] ? 8'hFF : 8'h7F));
			rd(umf_pkg::OFS_RX_ERR, 8'h00);
			wr(umf_pkg::OFS_MODE, {3'b100, cs[14:10]});
		end
		$display("test frame formats done");
		wr(umf_pkg::OFS_MODE, 8'h1C);
		wr(umf_pkg::OFS_CTRL, 8'h02);
		wr(umf_pkg::OFS_MODE, 8'h9C);
		wr(umf_pkg::OFS_MODE, 8'hFC);
		v = frame(8'h55, 5'b11100, 1'b1, n);
		umf_remote_inst.send(v ^ 12'h200, n);
		rd(umf_pkg::OFS_RX_ERR, 8'h01 << umf_pkg::RXE_PARITY_BIT);
		umf_remote_inst.send(v, n);
		wr(umf_pkg::OFS_TX_BUF, 8'hA5);
		wr(umf_pkg::OFS_MODE, 8'h9C);
		wr(umf_pkg::OFS_MODE, 8'h1C);
		rd(umf_pkg::OFS_RX_BUF, 8'h00);
		rd(umf_pkg::OFS_RX_ERR, 8'h00);
		rd(umf_pkg::OFS_TX_STAT, 8'h00);
		`CHK(tx_pin_out, 1'b1)
		$display("test parity and power off done");
		wr(umf_pkg::OFS_MODE, 8'h9C);
		wr(umf_pkg::OFS_TX_BUF, 8'hA5);
		umf_remote_inst.send(v, n);
		rd(umf_pkg::OFS_TX_STAT, 8'h00);
		`CHK(tx_pin_out, 1'b1)
		rd(umf_pkg::OFS_RX_BUF, 8'h00);
		$display("test enables off done");
		wr(umf_pkg::OFS_IN_SW, 8'h01);
		wr(umf_pkg::OFS_P1_DIR, 8'hE7);
		wr(umf_pkg::OFS_MODE, 8'hBC);
		umf_remote_inst.send(v, n);
		rd(umf_pkg::OFS_RX_BUF, 8'h55);
		$display("test input switch done");
		conclude();
	end
endmodule : umf_uart_mode_ctrl_tb
`default_nettype wire
